//--- fltr_flag_latch.v
// Eight sticky flag bits that clear when the host reads them.
// Assumes event inputs and the read strobe are synchronous to clock.
`timescale 1ns/1ps
module fltr_flag_latch (
  input wire clock,
  input wire rst,
  input wire [7:0] event_in,
  input wire [7:0] valid_mask,
  input wire read_clear,
  output wire [7:0] flags
);
  reg [7:0] flag_reg;
  wire [7:0] flag_next;

  // A set in the same cycle as the read-clear wins, so no event is lost.
  assign flag_next = ((read_clear ? 8'h00 : flag_reg) | event_in) & valid_mask;

  // Sticky storage of the flags.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_reg <= 8'h00;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flags = flag_reg;
endmodule

//--- fltr_host_model.sv
// Host side of the register port, issuing single-byte writes and reads.
// Assumes the bench calls its task from one process only.
`timescale 1ns/1ps
module fltr_host_model (
  input wire clock,
  output logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00,
  output logic reg_wr = 0, reg_rd = 0,
  input wire [7:0] reg_rdata
);
  // One-cycle strobe; on release address and data are inverted and both strobes cleared so stale values never pass for data.
  task acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clock) #1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
    @(posedge clock) #1;
    q = reg_rdata;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
  endtask
endmodule

//--- fltr_map.vh
// Register map, field positions and reset values for the timing, temperature and flag registers.
// Assumes an 8-bit register port with an 8-bit address, as seen from the serial interface decoder.
`ifndef FLTR_MAP_VH
`define FLTR_MAP_VH

`define FLTR_ADDR_TIMING 8'h08
`define FLTR_ADDR_TEMP 8'h09
`define FLTR_ADDR_FAULT_FLAGS_PRIMARY 8'h0A
`define FLTR_ADDR_FAULT_FLAGS_SECONDARY 8'h0B
`define FLTR_ADDR_ID 8'h0C
`define FLTR_ADDR_LAST 8'h0D

// Timing register: ramp code in bits 6..4, time-out code in bits 3..0.
`define FLTR_TIMING_RESET 8'h1A
`define FLTR_TIMING_MASK 8'h7F
`define FLTR_RAMP_HI 6
`define FLTR_RAMP_LO 4
`define FLTR_TOUT_HI 3
`define FLTR_TOUT_LO 0

// Temperature register: bit 7 reserved.
`define FLTR_TEMP_RESET 8'h08
`define FLTR_TEMP_MASK 8'h7F
`define FLTR_POL_BIT 6
`define FLTR_OPEN_EN_BIT 5
`define FLTR_SHORT_EN_BIT 4
`define FLTR_THR_HI 3
`define FLTR_THR_LO 1
`define FLTR_FUNC_BIT 0

// Flag masks; reserved bits of the second flag register read as zero.
`define FLTR_FAULT_FLAGS_PRIMARY_MASK 8'hFF
`define FLTR_FAULT_FLAGS_SECONDARY_MASK 8'h1F
`define FLTR_LAST_MASK 8'h7F

// Identification: arbitrary neutral values, not tied to any real part.
`define FLTR_DEV_ID 3'h5
`define FLTR_SI_REV 3'h1

`endif

//--- fltr_regs.v
// Host register slice: timing and temperature configuration, two flag registers, ID and last flash code.
// Assumes the serial interface decoder presents single-cycle read and write strobes with an address.
`timescale 1ns/1ps
`include "fltr_map.vh"
module fltr_regs (
  input wire clock,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire torch_active,
  input wire flash_active,
  input wire infrared_mode_active,
  input wire rf_sync_event,
  input wire output_short_event,
  input wire first_led_output_short_event,
  input wire second_led_output_short_event,
  input wire current_limit_event,
  input wire thermal_shutdown_event,
  input wire undervoltage_lockout_event,
  input wire flash_timeout_event,
  input wire thermistor_short_event,
  input wire thermistor_open_event,
  input wire input_voltage_flash_monitor_trip_event,
  input wire overvoltage_protection_event,
  input wire temperature_trip_event,
  input wire monitor_code_valid,
  input wire [6:0] monitor_code,
  output wire [2:0] torch_ramp_code,
  output wire [3:0] flash_timeout_code,
  output wire torch_active_low,
  output wire torch_pulldown_enable,
  output wire thermistor_open_enable,
  output wire thermistor_short_enable,
  output wire [2:0] temperature_threshold_code,
  output wire pin_is_thermistor
);
  reg [7:0] timing_reg;
  reg [7:0] temp_reg;
  reg [6:0] last_reg;
  wire operating;
  wire wr_timing;
  wire wr_temp;
  wire rd_fault_flags_primary;
  wire rd_fault_flags_secondary;
  wire [7:0] fault_flags_primary;
  wire [7:0] fault_flags_secondary;
  wire [7:0] temp_next;

  // Address match used by the write and read-clear strobes; the read mux decodes with its own case.
  function hit;
    input [7:0] a;
    input [7:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  assign operating = torch_active | flash_active | infrared_mode_active;
  assign wr_timing = reg_wr & hit(reg_addr, `FLTR_ADDR_TIMING);
  assign wr_temp = reg_wr & hit(reg_addr, `FLTR_ADDR_TEMP);
  assign rd_fault_flags_primary = reg_rd & hit(reg_addr, `FLTR_ADDR_FAULT_FLAGS_PRIMARY);
  assign rd_fault_flags_secondary = reg_rd & hit(reg_addr, `FLTR_ADDR_FAULT_FLAGS_SECONDARY);

  // The polarity bit keeps its old value while any mode runs; a glitch on the pin input mid-flash is worse
  // than a lost write, which the host avoids by disabling first.
  assign temp_next = {1'b0, (operating ? temp_reg[`FLTR_POL_BIT] : reg_wdata[`FLTR_POL_BIT]),
                      reg_wdata[`FLTR_OPEN_EN_BIT:0]};

  // Configuration registers.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      timing_reg <= `FLTR_TIMING_RESET;
      temp_reg <= `FLTR_TEMP_RESET;
    end else begin
      if (wr_timing) begin
        timing_reg <= reg_wdata & `FLTR_TIMING_MASK;
      end
      if (wr_temp) begin
        temp_reg <= temp_next & `FLTR_TEMP_MASK;
      end
    end
  end

  // Last code written by the input voltage flash monitor.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      last_reg <= 7'h00;
    end else if (monitor_code_valid) begin
      last_reg <= monitor_code;
    end
  end

  // Decoded fields drive the analog side.
  assign torch_ramp_code = timing_reg[`FLTR_RAMP_HI:`FLTR_RAMP_LO];
  assign flash_timeout_code = timing_reg[`FLTR_TOUT_HI:`FLTR_TOUT_LO];
  assign torch_active_low = temp_reg[`FLTR_POL_BIT];
  assign torch_pulldown_enable = ~temp_reg[`FLTR_POL_BIT];
  assign thermistor_open_enable = temp_reg[`FLTR_OPEN_EN_BIT];
  assign thermistor_short_enable = temp_reg[`FLTR_SHORT_EN_BIT];
  assign temperature_threshold_code = temp_reg[`FLTR_THR_HI:`FLTR_THR_LO];
  assign pin_is_thermistor = temp_reg[`FLTR_FUNC_BIT];

  // Primary flags, bit 7 down to bit 0.
  fltr_flag_latch u_fault_flags_primary (
    .clock(clock),
    .rst(rst),
    .event_in({rf_sync_event, output_short_event, first_led_output_short_event, second_led_output_short_event,
               current_limit_event, thermal_shutdown_event, undervoltage_lockout_event,
               flash_timeout_event}),
    .valid_mask(`FLTR_FAULT_FLAGS_PRIMARY_MASK),
    .read_clear(rd_fault_flags_primary),
    .flags(fault_flags_primary)
  );

  // Secondary flags; the thermistor faults only latch when detection is enabled.
  fltr_flag_latch u_fault_flags_secondary (
    .clock(clock),
    .rst(rst),
    .event_in({3'b000, thermistor_short_event & thermistor_short_enable,
               thermistor_open_event & thermistor_open_enable, input_voltage_flash_monitor_trip_event,
               overvoltage_protection_event, temperature_trip_event}),
    .valid_mask(`FLTR_FAULT_FLAGS_SECONDARY_MASK),
    .read_clear(rd_fault_flags_secondary),
    .flags(fault_flags_secondary)
  );

  // Registered read data; unmapped addresses read zero.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `FLTR_ADDR_TIMING: reg_rdata <= timing_reg;
        `FLTR_ADDR_TEMP: reg_rdata <= temp_reg;
        `FLTR_ADDR_FAULT_FLAGS_PRIMARY: reg_rdata <= fault_flags_primary;
        `FLTR_ADDR_FAULT_FLAGS_SECONDARY: reg_rdata <= fault_flags_secondary;
        `FLTR_ADDR_ID: reg_rdata <= {2'b00, `FLTR_DEV_ID, `FLTR_SI_REV};
        `FLTR_ADDR_LAST: reg_rdata <= {1'b0, last_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

//--- fltr_regs_assertions.sv
// Concurrent checks on the ports of the register slice.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
module fltr_regs_chk (
  input wire clock, rst, reg_wr, reg_rd, torch_active, flash_active, infrared_mode_active,
  input wire flash_timeout_event, monitor_code_valid, torch_active_low, torch_pulldown_enable,
  input wire thermistor_open_enable, thermistor_short_enable, pin_is_thermistor,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire [6:0] monitor_code,
  input wire [2:0] torch_ramp_code, temperature_threshold_code,
  input wire [3:0] flash_timeout_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Decoded strobes; any operating level must freeze the polarity bit.
  wire op = torch_active | flash_active | infrared_mode_active;
  wire rda = reg_rd && reg_addr == 8'h0A;
  wire rdd = reg_rd && reg_addr == 8'h0D;
  chk_pull_inv: assert property (torch_pulldown_enable == !torch_active_low) else $error("pulldown");
  chk_pol_frozen: assert property (op |=> $stable(torch_active_low)) else $error("polarity moved");
  chk_timing_wr: assert property (reg_wr && reg_addr == 8'h08 |=>
    {torch_ramp_code, flash_timeout_code} == $past(reg_wdata[6:0])) else $error("timing");
  chk_temp_wr: assert property (reg_wr && reg_addr == 8'h09 |=> {thermistor_open_enable,
    thermistor_short_enable, temperature_threshold_code, pin_is_thermistor} == $past(reg_wdata[5:0])) else $error("temp");
  chk_id_read: assert property (reg_rd && reg_addr == 8'h0C |=> reg_rdata == 8'h29) else $error("id");
  chk_fault_flags_secondary_rsvd: assert property (reg_rd && reg_addr == 8'h0B |=> reg_rdata[7:5] == 3'h0) else $error("rsvd");
  chk_flag_latch: assert property (flash_timeout_event ##1 !reg_rd ##1 rda |=> reg_rdata[0]) else $error("flag");
  chk_last_code: assert property (monitor_code_valid ##1 !monitor_code_valid ##1 rdd |=>
    reg_rdata == {1'b0, $past(monitor_code, 3)}) else $error("last code");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
endmodule
bind fltr_regs fltr_regs_chk u_chk (.*);

//--- fltr_regs_tb.sv
// Self-checking bench for the timing, temperature and flag registers.
// Assumes the host model drives the port and the checker is bound in.
`timescale 1ns/1ps
module fltr_regs_tb;
  logic clock = 0, rst = 1, torch_active = 0, flash_active = 0, infrared_mode_active = 0, monitor_code_valid = 0;
  logic [12:0] ev = 0;
  logic [6:0] monitor_code = 0;
  logic [7:0] q;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, torch_active_low, torch_pulldown_enable;
  wire thermistor_open_enable, thermistor_short_enable, pin_is_thermistor;
  wire [2:0] torch_ramp_code, temperature_threshold_code;
  wire [3:0] flash_timeout_code;
  int n_fail = 0, compares = 0;
  typedef struct {logic [7:0] a, d, e;} fltr_row_t;
  fltr_row_t rows[7] = '{'{8'h08, 8'h00, 8'h00}, '{8'h08, 8'hFF, 8'h7F}, '{8'h09, 8'hFF, 8'h7F},
    '{8'h09, 8'h80, 8'h00}, '{8'h0A, 8'hFF, 8'h00}, '{8'h0C, 8'h00, 8'h29}, '{8'h0E, 8'hFF, 8'h00}};
  fltr_host_model host (.*);
  fltr_regs DUT (.*, .rf_sync_event(ev[12]), .output_short_event(ev[11]), .first_led_output_short_event(ev[10]),
    .second_led_output_short_event(ev[9]), .current_limit_event(ev[8]), .thermal_shutdown_event(ev[7]),
    .undervoltage_lockout_event(ev[6]), .flash_timeout_event(ev[5]), .thermistor_short_event(ev[4]),
    .thermistor_open_event(ev[3]), .input_voltage_flash_monitor_trip_event(ev[2]),
    .overvoltage_protection_event(ev[1]), .temperature_trip_event(ev[0]));
  always #12.5 clock = ~clock;
  task chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rdc(input logic [7:0] a, e);
    host.acc(0, a, 8'h00, q);
    chk(q, e);
  endtask
  task wr(input logic [7:0] a, d);
    host.acc(1, a, d, q);
  endtask
  task wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // A hang is cut short here and counted as a mismatch.
  initial begin
    #20us;
    n_fail++;
    wrap_up;
  end
  // Table rows first, then every code, then reset, freeze, flags and monitor cases.
  initial begin
    repeat (4) @(posedge clock);
    #1 rst = 0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    for (int i = 0; i < 16; i++) begin
      wr(8'h08, {1'b0, i[2:0], i[3:0]});
      chk({1'b0, torch_ramp_code, flash_timeout_code}, {1'b0, i[2:0], i[3:0]});
      wr(8'h09, {4'h0, i[2:0], i[3]});
      chk({4'h0, temperature_threshold_code, pin_is_thermistor}, {4'h0, i[2:0], i[3]});
    end
    rst = 1;
    repeat (2) @(posedge clock);
    #1 rst = 0;
    rdc(8'h08, 8'h1A);
    rdc(8'h09, 8'h08);
    rdc(8'h0D, 8'h00);
    chk({7'h0, torch_pulldown_enable}, 8'h01);
    torch_active = 1;
    wr(8'h09, 8'h43);
    rdc(8'h09, 8'h03);
    torch_active = 0;
    wr(8'h09, 8'h71);
    rdc(8'h09, 8'h71);
    infrared_mode_active = 1;
    wr(8'h09, 8'h31);
    rdc(8'h09, 8'h71);
    infrared_mode_active = 0;
    ev = 13'h1FFF;
    @(posedge clock) #1 ev = 0;
    rdc(8'h0A, 8'hFF);
    rdc(8'h0A, 8'h00);
    rdc(8'h0B, 8'h1F);
    rdc(8'h0B, 8'h00);
    {monitor_code, monitor_code_valid} = {7'h55, 1'b1};
    @(posedge clock) #1 monitor_code_valid = 0;
    rdc(8'h0D, 8'h55);
    flash_active = 1;
    wr(8'h09, 8'h01);
    rdc(8'h09, 8'h41);
    chk({7'h0, torch_active_low}, 8'h01);
    flash_active = 0;
    ev = 13'h0018;
    @(posedge clock) #1 ev = 0;
    rdc(8'h0B, 8'h00);
    wrap_up;
  end
endmodule
